// [common/bscce_pkg.sv]
// Package with encodings, field positions and reset values for the decoder.
package bscce_pkg;

  // ****************************************************************
  // Instruction encodings and field positions
  // ****************************************************************
  localparam logic [3:0]  BTSS_OPC      = 4'h7;
  localparam logic [3:0]  CALL_OPC      = 4'h9;
  localparam logic [11:0] CLEAR_WORKING_REG_OP_WORD     = 12'h040;
  localparam logic [11:0] NOP_WORD      = 12'h000;
  localparam int          OPC_HI        = 11;
  localparam int          OPC_LO        = 8;
  localparam int          BIT_HI        = 7;
  localparam int          BIT_LO        = 5;
  localparam int          FADDR_HI      = 4;
  localparam int          FADDR_LO      = 0;
  localparam int          LIT_HI        = 7;
  localparam int          LIT_LO        = 0;

  // ****************************************************************
  // Status bit positions and reset values
  // ****************************************************************
  localparam int          STAT_Z        = 2;
  localparam int          STAT_PA_HI    = 6;
  localparam int          STAT_PA_LO    = 5;
  localparam logic [10:0] PC_RESET      = 11'h7ff;
  localparam logic [7:0]  W_RESET       = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h18;

  // Execution phase: normal or flushing a discarded prefetch.
  typedef enum logic [1:0] {
    PH_EXEC  = 2'b01,
    PH_FLUSH = 2'b10
  } bscce_phase_type;

endpackage

// [src/bscce_core.sv]
// Decode and execute logic for bit test skip, call and working clear.
`timescale 1ns/1ps

module bscce_core #(
  parameter int PC_W = 11
) (
  // Clock and reset.
  input  wire logic            mclk,
  input  wire logic            srst,
  // Fetch side: the word being executed.
  input  wire logic [11:0]     instr_word,
  // Register file read port, combinational from file_addr.
  input  wire logic [7:0]      file_rdata,
  output logic      [4:0]      file_addr,
  // Program counter and flush marker back to fetch.
  output logic      [PC_W-1:0] pc_out,
  output logic                 flush_out,
  // Hardware stack push.
  output logic                 stack_push,
  output logic      [PC_W-1:0] stack_top_entry,
  // Working and status registers.
  output logic      [7:0]      w_out,
  output logic      [7:0]      status_out
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  logic [PC_W-1:0]             pc_reg;
  logic [PC_W-1:0]             pc_next;
  logic [7:0]                  w_reg;
  logic [7:0]                  status_reg;
  bscce_pkg::bscce_phase_type  phase_reg;
  logic [11:0]                 op;
  logic                        is_btss;
  logic                        is_call;
  logic                        is_clear_working_reg_op;
  logic                        skip_hit;

  // Decodes only while executing; a flushed slot behaves as a no-op.
  always_comb begin
    op = (phase_reg == bscce_pkg::PH_FLUSH) ? bscce_pkg::NOP_WORD
                                             : instr_word;
    is_btss = op[bscce_pkg::OPC_HI:bscce_pkg::OPC_LO] == bscce_pkg::BTSS_OPC;
    is_call = op[bscce_pkg::OPC_HI:bscce_pkg::OPC_LO] == bscce_pkg::CALL_OPC;
    is_clear_working_reg_op = op == bscce_pkg::CLEAR_WORKING_REG_OP_WORD;
    skip_hit = is_btss
             && file_rdata[op[bscce_pkg::BIT_HI:bscce_pkg::BIT_LO]];
  end

  // Register file address comes straight from the current word.
  assign file_addr = instr_word[bscce_pkg::FADDR_HI:bscce_pkg::FADDR_LO];

  // Next program counter for each instruction.
  always_comb begin
    pc_next = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
    if (is_call) begin
      pc_next = {status_reg[bscce_pkg::STAT_PA_HI:bscce_pkg::STAT_PA_LO],
                 1'b0,
                 op[bscce_pkg::LIT_HI:bscce_pkg::LIT_LO]};
    end
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************

  // Program counter; a skip falls out of two sequential increments.
  always_ff @(posedge mclk) begin
    if (srst) begin
      pc_reg <= bscce_pkg::PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Phase: a taken skip or a call flushes the next fetched word.
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_reg <= bscce_pkg::PH_EXEC;
    end else begin
      case (phase_reg)
        bscce_pkg::PH_EXEC: begin
          if (skip_hit || is_call) begin
            phase_reg <= bscce_pkg::PH_FLUSH;
          end
        end
        bscce_pkg::PH_FLUSH: begin
          phase_reg <= bscce_pkg::PH_EXEC;
        end
        default: begin
          phase_reg <= bscce_pkg::PH_EXEC;
        end
      endcase
    end
  end

  // Stack push of the return address.
  always_ff @(posedge mclk) begin
    if (srst) begin
      stack_push      <= 1'b0;
      stack_top_entry <= '0;
    end else begin
      stack_push <= is_call;
      if (is_call) begin
        stack_top_entry <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Working register and status; bit test leaves both untouched.
  always_ff @(posedge mclk) begin
    if (srst) begin
      w_reg      <= bscce_pkg::W_RESET;
      status_reg <= bscce_pkg::STATUS_RESET;
    end else if (is_clear_working_reg_op) begin
      w_reg <= 8'h00;
      status_reg[bscce_pkg::STAT_Z] <= 1'b1;
    end
  end

  // Registered copy of the flush marker output.
  always_ff @(posedge mclk) begin
    if (srst) begin
      flush_out <= 1'b0;
    end else begin
      flush_out <= skip_hit || is_call;
    end
  end

  assign pc_out     = pc_reg;
  assign w_out      = w_reg;
  assign status_out = status_reg;

endmodule

// [verification/bscce_checker.sv]
// Assertions on the decode and execute ports of the core.
`timescale 1ns/1ps
module bscce_checker #(parameter int PC_W = 11) (
  // Clock and reset.
  input wire logic            mclk, srst,
  // Executed word and operand.
  input wire logic [11:0]     instr_word,
  input wire logic [7:0]      file_rdata,
  // Results.
  input wire logic            flush_out, stack_push,
  input wire logic [PC_W-1:0] pc_out, stack_top_entry,
  input wire logic [7:0]      w_out, status_out
);
  // Decode of the word taken at the coming edge.
  wire logic ex = !flush_out;
  wire logic cl = ex && instr_word[11:8] == 4'h9;
  wire logic bt = ex && instr_word[11:8] == 4'h7;
  wire logic cw = ex && instr_word == 12'h040;
  wire logic hit = file_rdata[instr_word[7:5]];
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_take; bt && hit; endsequence
  property p_skip; s_take |=> flush_out && $stable(status_out); endproperty
  a_skip: assert property (p_skip) else $error("skip lost");
  property p_stay; bt && !hit |=> !flush_out && $stable(status_out);
  endproperty
  a_stay: assert property (p_stay) else $error("bad skip");
  property p_cpc; cl |=> pc_out ==
    {$past(status_out[6:5]), 1'b0, $past(instr_word[7:0])}; endproperty
  a_cpc: assert property (p_cpc) else $error("call pc");
  property p_cpush; cl |=> stack_push && flush_out &&
    stack_top_entry == $past(pc_out) + 1'b1; endproperty
  a_cpush: assert property (p_cpush) else $error("push");
  property p_clr; cw |=> w_out == 8'h00 && status_out[2]; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_keep; cw |=> (status_out & 8'hfb) == ($past(status_out) & 8'hfb);
  endproperty
  a_keep: assert property (p_keep) else $error("flags");
  property p_fl; flush_out |=> $stable(w_out) && $stable(status_out) &&
    !stack_push; endproperty
  a_fl: assert property (p_fl) else $error("flush ran");
  property p_pc; !cl |=> pc_out == $past(pc_out) + 1'b1; endproperty
  a_pc: assert property (p_pc) else $error("pc step");
endmodule
bind bscce_core bscce_checker #(.PC_W(PC_W)) u_chk (.mclk(mclk), .srst(srst),
  .instr_word(instr_word), .file_rdata(file_rdata), .flush_out(flush_out),
  .stack_push(stack_push), .pc_out(pc_out), .stack_top_entry(stack_top_entry),
  .w_out(w_out), .status_out(status_out));

// [verification/bscce_tb_top.sv]
// Self-checking bench for the decode and execute core.
`timescale 1ns/1ps
module bscce_tb_top;
  logic        mclk, srst, flush_out, stack_push, fl, c, s;
  logic [11:0] instr_word, x;
  logic [7:0]  file_rdata, w_out, status_out, st;
  logic [4:0]  file_addr;
  logic [10:0] pc_out, stack_top_entry, pc, ste;
  logic [31:0] r, q[$];
  int          fail_count, n_tests;
  bscce_core dut (.mclk(mclk), .srst(srst), .instr_word(instr_word),
    .file_rdata(file_rdata), .file_addr(file_addr), .pc_out(pc_out),
    .flush_out(flush_out), .stack_push(stack_push), .w_out(w_out),
    .stack_top_entry(stack_top_entry), .status_out(status_out));
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD outputs exp %h seen %h", exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Clock and watchdog.
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #20000;
    fail_count++;
    finish_test;
  end
  // Monitor takes the oldest expectation once outputs have settled.
  always @(negedge mclk) begin
    if (q.size() > 0) chk({flush_out, pc_out, status_out, stack_push,
      stack_top_entry}, q.pop_front());
  end
  // Random words drive the core; a model notes each expected result.
  initial begin
    {srst, instr_word, file_rdata, r} = {1'b1, 20'h00000, 32'h6b91f850};
    {pc, fl, st, ste, fail_count, n_tests} = {11'h7ff, 1'b0, 8'h18, 11'h0, 64'h0};
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (400) begin
      r = nx(r);
      x = r[1:0] == 2'h0 ? {4'h7, r[10:3]} : r[1:0] == 2'h1 ? {4'h9, r[10:3]}
        : r[1:0] == 2'h2 ? 12'h040 : r[15:4];
      instr_word <= x;
      file_rdata <= r[23:16];
      @(posedge mclk);
      c = !fl && x[11:8] == 4'h9;
      s = !fl && x[11:8] == 4'h7 && r[16 + x[7:5]];
      if (c) ste = pc + 11'h001;
      if (!fl && x == 12'h040) st[2] = 1'b1;
      pc = c ? {st[6:5], 1'b0, x[7:0]} : pc + 11'h001;
      fl = c || s;
      q.push_back({fl, pc, st, c, ste});
    end
    @(negedge mclk);
    finish_test;
  end
endmodule
